// ### inc/sarmc_pkg.sv
`default_nettype none
package sarmc_pkg;
  // converter resolution and sar trial seed
  localparam int          RES_W      = 14;
  localparam logic [13:0] TRIAL_INIT = 14'h2000;
  localparam logic [3:0]  MSB_IDX    = 4'hd;
  localparam logic [3:0]  LSB_IDX    = 4'h0;

  // clock and throughput figures
  localparam int CLK_PERIOD_NS = 10;
  localparam int WARP_KSPS     = 1000;
  localparam int NORMAL_KSPS   = 800;
  localparam int IMPULSE_KSPS  = 670;
  localparam int NS_PER_MS     = 1000000;

  // least cycles per conversion period, rounded up
  localparam int WARP_PER_CYC =
    (NS_PER_MS + WARP_KSPS * CLK_PERIOD_NS - 1) / (WARP_KSPS * CLK_PERIOD_NS);
  localparam int NORMAL_PER_CYC =
    (NS_PER_MS + NORMAL_KSPS * CLK_PERIOD_NS - 1) /
    (NORMAL_KSPS * CLK_PERIOD_NS);
  localparam int IMPULSE_PER_CYC =
    (NS_PER_MS + IMPULSE_KSPS * CLK_PERIOD_NS - 1) /
    (IMPULSE_KSPS * CLK_PERIOD_NS);

  // sar step: dac settle plus comparator synchroniser
  localparam int          STEP_CYC      = 4;
  localparam logic [2:0]  STEP_LAST     = 3'(STEP_CYC - 1);
  localparam int          CONV_CYC      = RES_W * STEP_CYC + 1;
  localparam int          ACQ_OVERHEAD  = 1; // edge that clears the timer
  localparam logic [7:0]  WARP_ACQ_CYC  =
    8'(WARP_PER_CYC - CONV_CYC - ACQ_OVERHEAD);
  localparam logic [7:0]  NORMAL_ACQ_CYC =
    8'(NORMAL_PER_CYC - CONV_CYC - ACQ_OVERHEAD);
  localparam logic [7:0]  IMPULSE_ACQ_CYC =
    8'(IMPULSE_PER_CYC - CONV_CYC - ACQ_OVERHEAD);

  // warp calibration staleness interval
  localparam int WARP_IDLE_MS  = 1;
  localparam int WARP_IDLE_CYC = WARP_IDLE_MS * NS_PER_MS / CLK_PERIOD_NS;

  // register port map (word index)
  localparam logic [1:0] REG_CFG    = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_RESULT = 2'h2;

  // configuration field positions
  localparam int CFG_W      = 5;
  localparam int CFG_FAST   = 0;
  localparam int CFG_PSAVE  = 1;
  localparam int CFG_BIP    = 2;
  localparam int CFG_TEN    = 3;
  localparam int CFG_CODING = 4;
  localparam logic [4:0] CFG_RESET = 5'h10;

  // status field positions
  localparam int ST_BUSY  = 0;
  localparam int ST_PD    = 1;
  localparam int ST_STALE = 2;
  localparam int ST_MODE  = 3;
  localparam int ST_RANGE = 5;
  localparam int ST_COD   = 7;

  // synchroniser lane positions
  localparam int SY_W     = 8;
  localparam int SY_CNV   = 0;
  localparam int SY_FAST  = 1;
  localparam int SY_PSAVE = 2;
  localparam int SY_BIP   = 3;
  localparam int SY_TEN   = 4;
  localparam int SY_COD   = 5;
  localparam int SY_SWCFG = 6;
  localparam int SY_COMP  = 7;

  // operating mode codes on mode_o
  localparam logic [1:0] MODE_NORMAL  = 2'h0;
  localparam logic [1:0] MODE_WARP    = 2'h1;
  localparam logic [1:0] MODE_IMPULSE = 2'h2;
endpackage
`default_nettype wire

// ### logic/sarmc_sar.sv
`timescale 1ns/1ps
`default_nettype none
module sarmc_sar (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  input  wire logic        start_i,
  input  wire logic        comp_i,
  output logic             done_o,
  output logic [13:0]      code_o
);
  logic [3:0] idx_r;
  logic [2:0] step_r;
  logic       run_r;
  logic       step_end;

  assign step_end = run_r && (step_r == sarmc_pkg::STEP_LAST);

  // step timer and bit index, msb first
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idx_r  <= 4'h0;
      step_r <= 3'h0;
      run_r  <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (start_i) begin
        idx_r  <= sarmc_pkg::MSB_IDX;
        step_r <= 3'h0;
        run_r  <= 1'b1;
      end else if (run_r) begin
        step_r <= step_r + 3'h1;
        if (step_end) begin
          step_r <= 3'h0;
          if (idx_r == sarmc_pkg::LSB_IDX) begin
            run_r  <= 1'b0;
            done_o <= 1'b1;
          end else begin
            idx_r <= idx_r - 4'h1;
          end
        end
      end
    end
  end

  // per-bit trial: keep on comparator high, seed next lower bit
  // full-scale inputs walk to all ones or all zeros, saturating
  for (genvar i = 0; i < sarmc_pkg::RES_W; i++) begin : g_bit
    localparam logic [3:0] BIT_IDX   = 4'(i);
    localparam logic [3:0] BIT_ABOVE = 4'(i + 1);
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        code_o[i] <= 1'b0;
      end else if (ce_i) begin
        if (start_i) begin
          code_o[i] <= sarmc_pkg::TRIAL_INIT[i];
        end else if (step_end && idx_r == BIT_IDX) begin
          code_o[i] <= comp_i;
        end else if (step_end && idx_r == BIT_ABOVE) begin
          code_o[i] <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### logic/sarmc_ctrl.sv
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module sarmc_ctrl #(
  parameter int WARP_IDLE_CYC = sarmc_pkg::WARP_IDLE_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  input  wire logic        convert_start_n_i,
  input  wire logic        fast_mode_sel_i,
  input  wire logic        power_save_sel_i,
  input  wire logic        range_bipolar_i,
  input  wire logic        range_ten_i,
  input  wire logic        output_coding_select_i,
  input  wire logic        sw_config_en_i,
  input  wire logic        comp_i,
  input  wire logic [1:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [15:0]      reg_rdata_o,
  output logic             busy_o,
  output logic [13:0]      result_o,
  output logic [13:0]      trial_o,
  output logic             power_down_o,
  output logic             warp_stale_o,
  output logic [1:0]       mode_o,
  output logic [1:0]       range_o
);
  typedef enum logic {SARMC_ACQ, SARMC_CONV} sarmc_state_t;

  localparam int CONV_LAT = sarmc_pkg::CONV_CYC;

  sarmc_state_t                    state_r;
  logic [sarmc_pkg::SY_W-1:0]      sync1_r;
  logic [sarmc_pkg::SY_W-1:0]      sync2_r;
  logic                            cnv_prev_r;
  logic [sarmc_pkg::CFG_W-1:0]     cfg_r;
  logic [sarmc_pkg::CFG_W-1:0]     cfg_eff;
  logic [sarmc_pkg::CFG_W-1:0]     cfg_act_r;
  logic [7:0]                      acq_cnt_r;
  logic [7:0]                      acq_need;
  logic [1:0]                      mode_act;
  logic [16:0]                     idle_cnt_r;
  logic                            cnv_fall;
  logic                            acq_done;
  logic                            start;
  logic                            sar_done;
  logic [13:0]                     sar_code;

  // two-flop synchronisers for every pin and the comparator
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_r    <= 8'hff;
      sync2_r    <= 8'hff;
      cnv_prev_r <= 1'b1;
    end else if (ce_i) begin
      sync1_r    <= {comp_i, sw_config_en_i, output_coding_select_i,
                     range_ten_i, range_bipolar_i, power_save_sel_i,
                     fast_mode_sel_i, convert_start_n_i};
      sync2_r    <= sync1_r;
      cnv_prev_r <= sync2_r[sarmc_pkg::SY_CNV];
    end
  end

  // falling edge of the start pin
  assign cnv_fall = cnv_prev_r && !sync2_r[sarmc_pkg::SY_CNV];

  // pin or register source for range, mode and coding
  always_comb begin
    if (sync2_r[sarmc_pkg::SY_SWCFG]) begin
      cfg_eff = cfg_r;
    end else begin
      cfg_eff = {sync2_r[sarmc_pkg::SY_COD], sync2_r[sarmc_pkg::SY_TEN],
                 sync2_r[sarmc_pkg::SY_BIP], sync2_r[sarmc_pkg::SY_PSAVE],
                 sync2_r[sarmc_pkg::SY_FAST]};
    end
  end

  // mode decode from active selects
  always_comb begin
    case ({cfg_act_r[sarmc_pkg::CFG_FAST], cfg_act_r[sarmc_pkg::CFG_PSAVE]})
      2'b10:   mode_act = sarmc_pkg::MODE_WARP;
      2'b01:   mode_act = sarmc_pkg::MODE_IMPULSE;
      default: mode_act = sarmc_pkg::MODE_NORMAL;
    endcase
  end

  // acquisition length sets the throughput ceiling per mode
  always_comb begin
    case (mode_act)
      sarmc_pkg::MODE_WARP:    acq_need = sarmc_pkg::WARP_ACQ_CYC;
      sarmc_pkg::MODE_IMPULSE: acq_need = sarmc_pkg::IMPULSE_ACQ_CYC;
      default:                 acq_need = sarmc_pkg::NORMAL_ACQ_CYC;
    endcase
  end

  // a pending configuration change restarts acquisition first
  assign acq_done = (acq_cnt_r >= acq_need) && (cfg_eff == cfg_act_r);
  assign start    = (state_r == SARMC_ACQ) && cnv_fall && acq_done;

  // acquire / convert sequencing
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= SARMC_ACQ;
    end else if (ce_i) begin
      case (state_r)
        SARMC_ACQ: begin
          if (start) begin
            state_r <= SARMC_CONV;
          end
        end
        SARMC_CONV: begin
          if (sar_done) begin
            state_r <= SARMC_ACQ;
          end
        end
        default: state_r <= SARMC_ACQ;
      endcase
    end
  end

  // acquisition timer, restarted by any configuration change
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acq_cnt_r <= 8'h0;
      cfg_act_r <= sarmc_pkg::CFG_RESET;
    end else if (ce_i) begin
      if (state_r != SARMC_ACQ) begin
        acq_cnt_r <= 8'h0;
      end else if (cfg_eff != cfg_act_r) begin
        acq_cnt_r <= 8'h0;
        cfg_act_r <= cfg_eff;
      end else if (!acq_done) begin
        acq_cnt_r <= acq_cnt_r + 8'h1;
      end
    end
  end

  // successive approximation engine
  sarmc_sar u_sar (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .ce_i    (ce_i),
    .start_i (start),
    .comp_i  (sync2_r[sarmc_pkg::SY_COMP]),
    .done_o  (sar_done),
    .code_o  (sar_code)
  );

  assign trial_o = sar_code;

  // busy, result and power-down at conversion end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_o       <= 1'b0;
      result_o     <= 14'h0;
      power_down_o <= 1'b0;
    end else if (ce_i) begin
      if (start) begin
        busy_o       <= 1'b1;
        power_down_o <= 1'b0;
      end else if (sar_done) begin
        busy_o <= 1'b0;
        if (cfg_act_r[sarmc_pkg::CFG_CODING]) begin
          result_o <= sar_code;
        end else begin
          result_o <= {~sar_code[13], sar_code[12:0]};
        end
        power_down_o <= (mode_act == sarmc_pkg::MODE_IMPULSE);
      end else if (mode_act != sarmc_pkg::MODE_IMPULSE) begin
        power_down_o <= 1'b0;
      end
    end
  end

  // active mode and range, for the analog front end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_o  <= sarmc_pkg::MODE_NORMAL;
      range_o <= 2'h0;
    end else if (ce_i) begin
      mode_o  <= mode_act;
      range_o <= {cfg_act_r[sarmc_pkg::CFG_BIP],
                  cfg_act_r[sarmc_pkg::CFG_TEN]};
    end
  end

  // idle timer since last start; flags stale warp calibration
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle_cnt_r   <= 17'h0;
      warp_stale_o <= 1'b0;
    end else if (ce_i) begin
      if (start) begin
        idle_cnt_r <= 17'h0;
      end else if (idle_cnt_r < 17'(WARP_IDLE_CYC)) begin
        idle_cnt_r <= idle_cnt_r + 17'h1;
      end
      if (start) begin
        warp_stale_o <= 1'b0;
      end else if (idle_cnt_r >= 17'(WARP_IDLE_CYC)) begin
        warp_stale_o <= (mode_act == sarmc_pkg::MODE_WARP);
      end
    end
  end

  // software configuration register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_r <= sarmc_pkg::CFG_RESET;
    end else if (ce_i && reg_wr_i && reg_addr_i == sarmc_pkg::REG_CFG) begin
      cfg_r <= reg_wdata_i[sarmc_pkg::CFG_W-1:0];
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 16'h0;
    end else if (ce_i) begin
      reg_rdata_o <= 16'h0;
      if (reg_rd_i) begin
        case (reg_addr_i)
          sarmc_pkg::REG_CFG: begin
            reg_rdata_o[sarmc_pkg::CFG_W-1:0] <= cfg_r;
          end
          sarmc_pkg::REG_STATUS: begin
            reg_rdata_o[sarmc_pkg::ST_BUSY]  <= busy_o;
            reg_rdata_o[sarmc_pkg::ST_PD]    <= power_down_o;
            reg_rdata_o[sarmc_pkg::ST_STALE] <= warp_stale_o;
            reg_rdata_o[sarmc_pkg::ST_MODE +: 2]  <= mode_o;
            reg_rdata_o[sarmc_pkg::ST_RANGE +: 2] <= range_o;
            reg_rdata_o[sarmc_pkg::ST_COD] <=
              cfg_act_r[sarmc_pkg::CFG_CODING];
          end
          sarmc_pkg::REG_RESULT: begin
            reg_rdata_o[13:0] <= result_o;
          end
          default: reg_rdata_o <= 16'h0;
        endcase
      end
    end
  end

  // checks, valid while ce_i stays high
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_start_sets_busy: assert property (
    start |=> busy_o ##1 busy_o) else $error("busy not raised on start");
  a_conv_latency: assert property (
    start |-> ##CONV_LAT sar_done) else $error("conversion length wrong");
  a_done_drops_busy: assert property (
    sar_done |=> !busy_o) else $error("busy held after done");
  a_early_edge_ignored: assert property (
    state_r == SARMC_ACQ && cnv_fall && !acq_done |=> !busy_o)
    else $error("conversion started before acquisition end");
  a_binary_code: assert property (
    sar_done && cfg_act_r[sarmc_pkg::CFG_CODING]
    |=> result_o == $past(sar_code)) else $error("binary code wrong");
  a_twos_code: assert property (
    sar_done && !cfg_act_r[sarmc_pkg::CFG_CODING]
    |=> result_o == {~$past(sar_code[13]), $past(sar_code[12:0])})
    else $error("twos complement code wrong");
  a_warp_select: assert property (
    mode_o == sarmc_pkg::MODE_WARP
    |-> $past(cfg_act_r[sarmc_pkg::CFG_FAST]) &&
        !$past(cfg_act_r[sarmc_pkg::CFG_PSAVE]))
    else $error("warp mode without its selects");
  a_normal_select: assert property (
    $past(cfg_act_r[sarmc_pkg::CFG_FAST]) ==
    $past(cfg_act_r[sarmc_pkg::CFG_PSAVE])
    |-> mode_o == sarmc_pkg::MODE_NORMAL) else $error("normal mode lost");
  a_impulse_powerdown: assert property (
    sar_done && mode_act == sarmc_pkg::MODE_IMPULSE |=> power_down_o)
    else $error("impulse mode did not power down");
  a_cfg_restarts_acq: assert property (
    state_r == SARMC_ACQ && cfg_eff != cfg_act_r
    |=> acq_cnt_r == 8'h0 && !busy_o) else $error("acquisition not restarted");

  c_conversion: cover property (start ##[1:80] sar_done);
  c_warp_conv: cover property (mode_act == sarmc_pkg::MODE_WARP && start);
  c_impulse_pd: cover property (power_down_o ##1 start);
  c_twos_result: cover property (
    sar_done && !cfg_act_r[sarmc_pkg::CFG_CODING]);
endmodule
`default_nettype wire

// ### dv/sarmc_ain_model.sv
`timescale 1ns/1ps
`default_nettype none
// analog input and comparator as the sar logic sees them
module sarmc_ain_model (
  input  wire logic [13:0] trial_i,
  input  wire logic [14:0] vin_i,
  output logic             comp_o
);
  // overrange input stays above every trial code, so it saturates
  assign comp_o = ({1'b0, trial_i} <= vin_i);
endmodule
`default_nettype wire

// ### dv/sarmc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sarmc_ctrl_tb;
  logic        clk_i      = 1'b0;
  logic        nrst_i     = 1'b0;
  logic        cnv_n      = 1'b1;
  logic        fast       = 1'b0;
  logic        psave      = 1'b0;
  logic        bip        = 1'b0;
  logic        ten        = 1'b0;
  logic        cod        = 1'b1;
  logic        swc        = 1'b0;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic [1:0]  addr       = 2'h0;
  logic [7:0]  wdata      = 8'h00;
  logic [14:0] vin        = 15'h0000;
  logic [14:0] vtab [4]   = '{15'h0000, 15'h2000, 15'h3fff, 15'h7fff};
  logic        comp;
  logic [15:0] rdata;
  logic [15:0] d;
  logic        busy;
  logic        pd;
  logic        stale;
  logic [13:0] result;
  logic [13:0] trial;
  logic [1:0]  mode;
  logic [1:0]  range;
  int          num_errors = 0;
  int          num_checks = 0;

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  sarmc_ctrl #(.WARP_IDLE_CYC(200)) sarmc_ctrl_inst (
    .clk_i                  (clk_i),
    .nrst_i                 (nrst_i),
    .ce_i                   (1'b1),
    .convert_start_n_i      (cnv_n),
    .fast_mode_sel_i        (fast),
    .power_save_sel_i       (psave),
    .range_bipolar_i        (bip),
    .range_ten_i            (ten),
    .output_coding_select_i (cod),
    .sw_config_en_i         (swc),
    .comp_i                 (comp),
    .reg_addr_i             (addr),
    .reg_wdata_i            (wdata),
    .reg_wr_i               (wr),
    .reg_rd_i               (rd),
    .reg_rdata_o            (rdata),
    .busy_o                 (busy),
    .result_o               (result),
    .trial_o                (trial),
    .power_down_o           (pd),
    .warp_stale_o           (stale),
    .mode_o                 (mode),
    .range_o                (range)
  );

  sarmc_ain_model sarmc_ain_model_inst (
    .trial_i (trial),
    .vin_i   (vin),
    .comp_o  (comp)
  );

  // verdict and end of run
  task automatic report_and_stop();
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // compare and count
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // expected mode from the two select pins
  function automatic logic [1:0] mode_of(input logic f, input logic p);
    if (f && !p) begin
      return sarmc_pkg::MODE_WARP;
    end
    if (p && !f) begin
      return sarmc_pkg::MODE_IMPULSE;
    end
    return sarmc_pkg::MODE_NORMAL;
  endfunction

  // expected code: clip overrange, then flip msb for twos complement
  function automatic logic [13:0] code_of(input logic [14:0] v,
                                          input logic bin);
    logic [13:0] b;
    b = (v > 15'h3fff) ? 14'h3fff : v[13:0];
    return bin ? b : (b ^ 14'h2000);
  endfunction

  // register write, one strobe cycle
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk_i);
    wr    <= 1'b0;
  endtask

  // register read, data in the cycle after the strobe
  task automatic reg_rd(input logic [1:0] a, output logic [15:0] v);
    @(posedge clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_i);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask

  // all configuration pins and the analog level at once
  task automatic drive_pins(input logic f, p, b, t, c, s,
                            input logic [14:0] v);
    @(posedge clk_i);
    fast  <= f;
    psave <= p;
    bip   <= b;
    ten   <= t;
    cod   <= c;
    swc   <= s;
    vin   <= v;
  endtask

  // bounded wait for busy to reach a level
  task automatic wait_busy(input logic lvl, input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (busy !== lvl && n < lim);
    if (busy !== lvl) begin
      num_errors++;
      report_and_stop();
    end
  endtask

  // one conversion after acq cycles of acquisition
  task automatic convert(input int acq, input logic [13:0] exp);
    int n;
    repeat (acq + 1) @(posedge clk_i);
    cnv_n <= 1'b0;
    wait_busy(1'b1, 10, n);
    check("trial_seed", {2'h0, trial}, 16'h2000);
    wait_busy(1'b0, 100, n);
    check("busy_cycles", 16'(n), 16'(sarmc_pkg::CONV_CYC));
    check("result", {2'h0, result}, {2'h0, exp});
    @(posedge clk_i);
    cnv_n <= 1'b1;
    #1;
  endtask

  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    // start edge arrives before acquisition has ended
    @(posedge clk_i);
    cnv_n <= 1'b0;
    repeat (20) @(posedge clk_i);
    #1 check("early_busy", {15'h0, busy}, 16'h0000);
    @(posedge clk_i);
    cnv_n <= 1'b1;
    reg_rd(sarmc_pkg::REG_STATUS, d);
    check("status_reset", d, 16'h0080);
    // every select pin combination
    for (int i = 0; i < 4; i++) begin
      drive_pins(i[0], i[1], 1'b0, 1'b0, 1'b1, 1'b0, 15'(i * 15'h1111));
      convert(110, code_of(15'(i * 15'h1111), 1'b1));
      check("mode", {14'h0, mode}, {14'h0, mode_of(i[0], i[1])});
      check("power_down", {15'h0, pd}, {15'h0, i == 2});
    end
    // ranges, both codings, scale ends and overrange
    for (int i = 0; i < 8; i++) begin
      drive_pins(1'b0, 1'b0, i[1], i[0], i[2], 1'b0, vtab[i % 4]);
      convert(110, code_of(vtab[i % 4], i[2]));
      check("range", {14'h0, range}, {14'h0, 2'(i % 4)});
    end
    // software mode: pins say otherwise and are ignored
    drive_pins(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 15'h2000);
    reg_wr(sarmc_pkg::REG_CFG, 8'h01);
    convert(110, 14'h0000);
    check("sw_mode", {14'h0, mode}, {14'h0, sarmc_pkg::MODE_WARP});
    check("sw_range", {14'h0, range}, 16'h0000);
    reg_wr(sarmc_pkg::REG_STATUS, 8'hff);
    reg_rd(sarmc_pkg::REG_STATUS, d);
    check("sw_status", d, 16'h0008);
    reg_rd(sarmc_pkg::REG_CFG, d);
    check("cfg_readback", d, 16'h0001);
    reg_rd(sarmc_pkg::REG_RESULT, d);
    check("reg_result", d, 16'h0000);
    reg_rd(2'h3, d);
    check("reg_unmapped", d, 16'h0000);
    // long idle in warp flags the next result as suspect
    repeat (210) @(posedge clk_i);
    #1 check("stale_set", {15'h0, stale}, 16'h0001);
    convert(0, 14'h0000);
    check("stale_clear", {15'h0, stale}, 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
